// ---- rtl/ftl_defs.svh ----
`ifndef FTL_DEFS_SVH
`define FTL_DEFS_SVH

// Register index (printed offsets are not all multiples of four: byte address = index * 4)
`define FTL_IDX_FAN_CFG     8'h58
`define FTL_IDX_TACH_A      8'h59
`define FTL_IDX_TACH_B      8'h5a
`define FTL_IDX_PRELOAD_A   8'h5b
`define FTL_IDX_PRELOAD_B   8'h5c
`define FTL_IDX_LAMP_A      8'h5d
`define FTL_IDX_LAMP_B      8'h5e
`define FTL_IDX_SCAN        8'h5f
`define FTL_IDX_RSVD_LO     8'h60
`define FTL_IDX_RSVD_HI     8'h7f

// Reset values
`define FTL_FAN_CFG_RST     8'h50
`define FTL_ZERO_RST        8'h00

// Field positions
`define FTL_DIV_A_LSB       4
`define FTL_DIV_B_LSB       6
`define FTL_LAMP_LSB        0

// Lamp codes
`define FTL_LAMP_OFF        2'h0
`define FTL_LAMP_BLINK_1HZ  2'h1
`define FTL_LAMP_BLINK_HALF 2'h2
`define FTL_LAMP_ON         2'h3

// Timing: half second slot of the lamp time base
`define FTL_CLK_HZ          125000000
`define FTL_SLOT_MS         500
`define FTL_SLOT_CYCLES     ((`FTL_CLK_HZ / 1000) * `FTL_SLOT_MS)
// Clocks per base counting tick of the tachometer counters
`define FTL_TICK_PRESCALE   125

// AXI responses
`define FTL_RESP_OKAY       2'h0
`define FTL_RESP_SLVERR     2'h2

`endif

// ---- rtl/ftl_fan_tach_led_regs.sv ----
// Summary of operation
// - First cooler divisor bits 5:4: 1,2,4,8
// - Second cooler divisor bits 7:6, same coding
// - Fan config resets to 0x50
// - Read-only 8-bit tick count per cooler
// - Count register shows latched final count
// - Reading unreliable two pulses after preload write
// - Read-write 8-bit preload per cooler
// - Preload write restarts that cooler counter
// - Lamp code 00 dark, 11 lit
// - Lamp code 01 blinks 1 Hz, 50%
// - Lamp code 10 blinks half Hz, 25%
// - Read-write eight-bit keyboard scan code byte
// - Offsets 0x60 to 0x7F read zero
`timescale 1ns/1ps
`include "ftl_defs.svh"

module ftl_fan_tach_led_regs #(
  parameter int unsigned SLOT_CYCLES = `FTL_SLOT_CYCLES,  // Half second in clocks
  parameter int unsigned TICK_PRESCALE = `FTL_TICK_PRESCALE  // Clocks per base tick
) (
  // Clock and asynchronous active-low reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Write address channel
  input  wire logic [9:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // Write data channel; only lane 0 holds register bits
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // Write response channel
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // Read address channel
  input  wire logic [9:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // Read data channel
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Tachometer pins from the coolers, not on this clock
  input  wire logic        FIRST_COOLER_TACH,
  input  wire logic        SECOND_COOLER_TACH,
  // Lamp drives, high means lit
  output logic             FIRST_LAMP,
  output logic             SECOND_LAMP
);

  // Register contents
  // Bytes are kept whole; lamp bits 7:2 are spare but stored and read back
  // All of them reset on RST_N, the standby-supply power-on reset
  logic [7:0]  fan_cfg_reg;              // Divisor fields
  logic [7:0]  preload_reg [2];          // Per cooler preload
  logic [7:0]  tach_reg    [2];          // Latched counts
  logic [7:0]  lamp_reg    [2];          // Lamp control bytes
  logic [7:0]  scan_reg;                 // Keyboard scan code byte

  // Write channel capture
  // Address and data are caught separately, so either may arrive first
  // A slow master may hold one channel without stalling the other
  logic        aw_have_reg;              // Write address held
  logic [7:0]  aw_idx_reg;               // Held word index
  logic        w_have_reg;               // Write data held
  logic [31:0] w_data_reg;               // Held write data
  logic [3:0]  w_strb_reg;               // Held strobes
  logic        wr_fire;                  // Both halves present, response free
  logic        wr_ok;                    // Write hits a mapped index
  logic [1:0]  pre_wr_reg;               // Preload write pulses per cooler

  // Decode whether an index is inside the register window
  // Anything outside answers SLVERR and leaves the registers alone
  function automatic logic idx_mapped(input logic [7:0] idx);
    idx_mapped = (idx >= `FTL_IDX_FAN_CFG) && (idx <= `FTL_IDX_RSVD_HI);
  endfunction

  // A write fires once address and data are both held and B is free
  assign wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;
  assign wr_ok   = idx_mapped(aw_idx_reg);

  // Write address channel: accept one, hold until the response is issued
  // AWREADY is a one-cycle pulse, so a held AWVALID is taken once only
  // A second address waits until the first write has been answered
  // The index is the byte address without its two low bits
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_reg   <= 1'b0;
      aw_idx_reg    <= 8'h00;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_reg <= 1'b1;
        aw_idx_reg  <= S_AXI_AWADDR[9:2];
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  // Write data channel, independent of address order
  // Same pulse scheme as the address side; the word waits in w_data_reg
  // Strobes are kept with it, since lane 0 decides whether a write lands
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_have_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_have_reg && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Write response: SLVERR outside the window
  // BVALID holds with its code until BREADY; no new write fires meanwhile
  // Writes to read-only or reserved indexes still answer OKAY
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `FTL_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? `FTL_RESP_OKAY : `FTL_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data
  // A cleared lane 0 strobe leaves every register untouched
  // pre_wr_reg is a one-cycle pulse that restarts the matching counter
  // The preload value is stored in the same edge, so the restart uses it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fan_cfg_reg    <= `FTL_FAN_CFG_RST;
      preload_reg[0] <= `FTL_ZERO_RST;
      preload_reg[1] <= `FTL_ZERO_RST;
      lamp_reg[0]    <= `FTL_ZERO_RST;
      lamp_reg[1]    <= `FTL_ZERO_RST;
      scan_reg       <= `FTL_ZERO_RST;
      pre_wr_reg     <= 2'b00;
    end else begin
      pre_wr_reg <= 2'b00;
      if (wr_fire && w_strb_reg[0]) begin
        // Index decides the target; unmapped ones fall to the default
        unique case (aw_idx_reg)
          `FTL_IDX_FAN_CFG:   fan_cfg_reg <= w_data_reg[7:0];
          `FTL_IDX_PRELOAD_A: begin
            preload_reg[0] <= w_data_reg[7:0];
            pre_wr_reg[0]  <= 1'b1;
          end
          `FTL_IDX_PRELOAD_B: begin
            preload_reg[1] <= w_data_reg[7:0];
            pre_wr_reg[1]  <= 1'b1;
          end
          `FTL_IDX_LAMP_A:    lamp_reg[0] <= w_data_reg[7:0];
          `FTL_IDX_LAMP_B:    lamp_reg[1] <= w_data_reg[7:0];
          `FTL_IDX_SCAN:      scan_reg    <= w_data_reg[7:0];
          default:            ;  // Read-only and reserved indexes ignore writes
        endcase
      end
    end
  end

  // Read data mux; reserved window reads zero
  // Tachometer counts are the latched values, never the running count
  // Unmapped indexes also give zero, next to their SLVERR code
  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    unique case (idx)
      `FTL_IDX_FAN_CFG:   read_byte = fan_cfg_reg;
      `FTL_IDX_TACH_A:    read_byte = tach_reg[0];
      `FTL_IDX_TACH_B:    read_byte = tach_reg[1];
      `FTL_IDX_PRELOAD_A: read_byte = preload_reg[0];
      `FTL_IDX_PRELOAD_B: read_byte = preload_reg[1];
      `FTL_IDX_LAMP_A:    read_byte = lamp_reg[0];
      `FTL_IDX_LAMP_B:    read_byte = lamp_reg[1];
      `FTL_IDX_SCAN:      read_byte = scan_reg;
      default:            read_byte = 8'h00;
    endcase
  endfunction

  // Read channel: ARREADY pulses, data one cycle later
  // ARREADY stays low while RVALID is up, so only one read is in flight
  // The address is decoded at the handshake edge; RDATA then holds
  // unchanged until RREADY is seen high
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `FTL_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h00_0000, read_byte(S_AXI_ARADDR[9:2])};
        S_AXI_RRESP  <= idx_mapped(S_AXI_ARADDR[9:2]) ? `FTL_RESP_OKAY : `FTL_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Base tick: the undivided internal counting clock
  // Its rate is not fixed by the register map; TICK_PRESCALE sets it,
  // and every count scales with it
  // A 16-bit prescaler limits TICK_PRESCALE to 65536
  logic [15:0] pre_cnt_reg;
  logic        base_tick;
  assign base_tick = (pre_cnt_reg == 16'(TICK_PRESCALE - 1));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_cnt_reg <= 16'h0000;
    end else begin
      pre_cnt_reg <= base_tick ? 16'h0000 : pre_cnt_reg + 16'h0001;
    end
  end

  // Per-cooler tachometer path
  // Each cooler has its own synchroniser, divider and counter; the two
  // share only the base tick, so their divisor fields act independently
  // Limitation: a period longer than 255 divided ticks reads as 0xff
  // Pins gathered so the generate loop can index them
  logic [1:0] tach_pin;
  assign tach_pin = {SECOND_COOLER_TACH, FIRST_COOLER_TACH};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cooler
      logic [2:0] sync_reg;     // Three-stage pin synchroniser
      logic       level_reg;    // Accepted level
      logic [2:0] div_cnt_reg;  // Divider of the base tick
      logic [7:0] cnt_reg;      // Running count
      logic       edge_seen;    // Rising tachometer edge accepted
      logic       div_tick;     // Divided counting tick
      ftl_pkg::ftl_div_type div_sel;

      assign div_sel = fan_cfg_reg[(g == 0 ? `FTL_DIV_A_LSB : `FTL_DIV_B_LSB) +: 2];
      // Divisor 1,2,4,8: tick when the low div_sel bits of the divider are all ones
      // The divider restarts after each tick, so the ratio is exact
      assign div_tick  = base_tick && ((div_cnt_reg & 3'((4'h1 << div_sel) - 4'h1)) ==
                                       3'((4'h1 << div_sel) - 4'h1));
      // Second and third stages must agree before the level changes
      // Only a rising edge counts as a pulse; the level must be low first
      assign edge_seen = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;

      // Synchroniser and debounced level
      // Reset to low matches an idle pin, so no false edge after reset
      // Needing two stages to agree also rejects a one-clock glitch
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          sync_reg  <= 3'b000;
          level_reg <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[1:0], tach_pin[g]};
          if (sync_reg[1] == sync_reg[2]) begin
            level_reg <= sync_reg[2];
          end
        end
      end

      // Count divided ticks from preload, latch per pulse
      // A preload write wins over an edge in the same cycle: the restart
      // must not be lost, and the pulse it drops is one readers ignore
      // Saturation makes an over-long period latch as the slowest speed; a stalled cooler keeps its last latch
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          div_cnt_reg <= 3'h0;
          cnt_reg     <= 8'h00;
          tach_reg[g] <= 8'h00;
        end else begin
          if (base_tick) begin
            div_cnt_reg <= div_tick ? 3'h0 : div_cnt_reg + 3'h1;
          end
          if (pre_wr_reg[g]) begin
            // Restart; old latch stays, so next reading is a partial period
            cnt_reg     <= preload_reg[g];
            div_cnt_reg <= 3'h0;
          end else if (edge_seen) begin
            tach_reg[g] <= cnt_reg;
            cnt_reg     <= preload_reg[g];
          end else if (div_tick && cnt_reg != 8'hff) begin
            cnt_reg <= cnt_reg + 8'h01;     // Saturating count
          end
        end
      end
    end
  endgenerate

  // Shared lamp time base: half-second slots, four slots per frame
  // A frame is two seconds; both blink patterns are cut from it, so the
  // lamps stay in step with each other
  // The slot counter is 32 bits so the full-rate slot length fits
  logic [31:0] slot_cnt_reg;
  logic [1:0]  slot_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slot_cnt_reg <= 32'h0000_0000;
      slot_reg     <= 2'h0;
    end else if (slot_cnt_reg == SLOT_CYCLES - 1) begin
      slot_cnt_reg <= 32'h0000_0000;
      slot_reg     <= slot_reg + 2'h1;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
    end
  end

  // Lamp pattern from mode and slot
  // Code 01 lights even slots, code 10 only the first slot of the frame
  function automatic logic lamp_level(input ftl_pkg::ftl_lamp_type mode, input logic [1:0] slot);
    unique case (mode)
      `FTL_LAMP_OFF:        lamp_level = 1'b0;
      `FTL_LAMP_BLINK_1HZ:  lamp_level = !slot[0];
      `FTL_LAMP_BLINK_HALF: lamp_level = (slot == 2'h0);
      `FTL_LAMP_ON:         lamp_level = 1'b1;
    endcase
  endfunction

  // Lamp outputs registered, each from its own field
  // The register adds one clock of lag, far below the half-second slot
  // A mode change shows within one clock, mid-slot if need be
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIRST_LAMP  <= 1'b0;
      SECOND_LAMP <= 1'b0;
    end else begin
      FIRST_LAMP  <= lamp_level(lamp_reg[0][`FTL_LAMP_LSB +: 2], slot_reg);
      SECOND_LAMP <= lamp_level(lamp_reg[1][`FTL_LAMP_LSB +: 2], slot_reg);
    end
  end

endmodule

// ---- rtl/ftl_pkg.sv ----
package ftl_pkg;
  // Divisor select code for a cooler tachometer
  typedef logic [1:0] ftl_div_type;
  // Lamp mode code
  typedef logic [1:0] ftl_lamp_type;
endpackage

// ---- tb/ftl_fan_model.sv ----
`timescale 1ns/1ps
// Two coolers: one 4-cycle tach pulse per period, period 0 stops the fan
module ftl_fan_model (
  input  wire logic        clk,
  input  wire logic [15:0] per_a,
  input  wire logic [15:0] per_b,
  output logic             tach_a,
  output logic             tach_b
);
  logic [15:0] cnt_a = 16'h0;  // Position in period
  logic [15:0] cnt_b = 16'h0;
  initial begin
    tach_a = 1'b0;
    tach_b = 1'b0;
  end
  // Pulse wider than the sync chain so no edge is lost
  always @(posedge clk) begin
    cnt_a <= (per_a == 16'h0 || cnt_a >= per_a - 16'h1) ? 16'h0 : cnt_a + 16'h1;
    cnt_b <= (per_b == 16'h0 || cnt_b >= per_b - 16'h1) ? 16'h0 : cnt_b + 16'h1;
    tach_a <= per_a != 16'h0 && cnt_a < 16'h4;
    tach_b <= per_b != 16'h0 && cnt_b < 16'h4;
  end
endmodule

// ---- tb/ftl_regs_properties.sv ----
`timescale 1ns/1ps
// Bus-side timing, data and response-code checks; bound to the register block
module ftl_regs_properties (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_aw_pulse; S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("AWREADY held");
  property p_w_pulse; S_AXI_WREADY |=> !S_AXI_WREADY; endproperty
  a_w_pulse: assert property (p_w_pulse) else $error("WREADY held");
  property p_ar_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_width; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
  a_r_width: assert property (p_r_width) else $error("upper read bits set");
  property p_r_err; S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("refused read not zero");
  property p_b_code; S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2; endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response");
endmodule
bind ftl_fan_tach_led_regs ftl_regs_properties u_props (.CLK(CLK), .RST_N(RST_N),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [15:0] per_a = 16'h0, per_b = 16'h0;
  logic [31:0] rdata, na, nb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, lamp_a, lamp_b, tach_a, tach_b;
  logic [31:0] lit [4] = '{32'h0, 32'h10, 32'h8, 32'h20};  // Lit cycles per 4 slots
  int          num_errors = 0, n_checks = 0, cyc = 0;

  // Short slot and prescale keep the run brief
  ftl_fan_tach_led_regs #(.SLOT_CYCLES(8), .TICK_PRESCALE(2)) u_dut (.CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .FIRST_COOLER_TACH(tach_a), .SECOND_COOLER_TACH(tach_b),
    .FIRST_LAMP(lamp_a), .SECOND_LAMP(lamp_b));
  ftl_fan_model u_fan (.clk(clk), .per_a(per_a), .per_b(per_b), .tach_a(tach_a), .tach_b(tach_b));

  initial forever #4 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end

  // Compare; t allows one count of slack for prescaler phase
  task chk(input logic [31:0] g, input logic [31:0] e, input bit t);
    n_checks++;
    if (!(g === e || (t && (g === e + 32'h1 || g === e - 32'h1)))) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e);
    @(posedge clk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(e), 1'b0);
  endtask
  task rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er, input bit t);
    @(posedge clk);
    araddr <= {i, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, {24'h0, e}, t);
    chk(32'(rresp), 32'(er), 1'b0);
  endtask

  task t_reset;
    rd(8'h58, 8'h50, 2'h0, 1'b0);
    for (int i = 8'h59; i < 8'h60; i++) rd(8'(i), 8'h00, 2'h0, 1'b0);
    $display("t_reset done");
  endtask
  task t_regs;
    wr(8'h5f, 8'h81, 2'h0);
    rd(8'h5f, 8'h81, 2'h0, 1'b0);
    wstrb <= 4'h0;
    wr(8'h5f, 8'h00, 2'h0);
    wstrb <= 4'hf;
    rd(8'h5f, 8'h81, 2'h0, 1'b0);
    wr(8'h58, 8'ha5, 2'h0);
    rd(8'h58, 8'ha5, 2'h0, 1'b0);
    wr(8'h5b, 8'hc3, 2'h0);
    rd(8'h5b, 8'hc3, 2'h0, 1'b0);
    wr(8'h59, 8'hff, 2'h0);
    rd(8'h59, 8'h00, 2'h0, 1'b0);
    wr(8'h60, 8'h77, 2'h0);
    rd(8'h60, 8'h00, 2'h0, 1'b0);
    rd(8'h7f, 8'h00, 2'h0, 1'b0);
    wr(8'h10, 8'h11, 2'h2);
    rd(8'h10, 8'h00, 2'h2, 1'b0);
    $display("t_regs done");
  endtask
  // Period 64 clocks; ticks every divisor*2 clocks, counts read after 4 pulses
  task t_tach;
    per_a <= 16'h40;
    per_b <= 16'h40;
    wr(8'h58, 8'h70, 2'h0);
    wr(8'h5b, 8'h10, 2'h0);
    wr(8'h5c, 8'h20, 2'h0);
    repeat (256) @(posedge clk);
    rd(8'h59, 8'h14, 2'h0, 1'b1);
    rd(8'h5a, 8'h30, 2'h0, 1'b1);
    wr(8'h58, 8'h80, 2'h0);
    wr(8'h5b, 8'hfe, 2'h0);
    wr(8'h5c, 8'h20, 2'h0);
    repeat (256) @(posedge clk);
    rd(8'h59, 8'hff, 2'h0, 1'b0);
    rd(8'h5a, 8'h28, 2'h0, 1'b1);
    // Stopped cooler, saturated count: only the restart explains a small first count
    per_a <= 16'h0;
    repeat (8) @(posedge clk);
    wr(8'h5b, 8'h00, 2'h0);
    per_a <= 16'h40;
    repeat (8) @(posedge clk);
    rd(8'h59, 8'h02, 2'h0, 1'b1);
    repeat (64) @(posedge clk);
    rd(8'h59, 8'h20, 2'h0, 1'b1);
    $display("t_tach done");
  endtask
  // Count lit cycles over four slots for every code, lamps set opposite
  task t_lamp;
    for (int c = 0; c < 4; c++) begin
      wr(8'h5d, 8'(c), 2'h0);
      wr(8'h5e, 8'(3 - c), 2'h0);
      repeat (32) @(posedge clk);
      na = 32'h0;
      nb = 32'h0;
      repeat (32) begin
        @(posedge clk);
        na = na + 32'(lamp_a);
        nb = nb + 32'(lamp_b);
      end
      chk(na, lit[c], 1'b0);
      chk(nb, lit[3 - c], 1'b0);
    end
    $display("t_lamp done");
  endtask

  task end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_tach;
    t_lamp;
    end_sim;
  end
endmodule
